/* File: hw/ara_pkg.sv */
package ara_pkg;
    // Register byte offsets; the converter's own map is byte addressed.
    localparam logic [7:0] ADDR_STAT_CTRL   = 8'h57;
    localparam logic [7:0] ADDR_CLK_CTRL    = 8'h58;
    localparam logic [7:0] ADDR_RES_HIGH    = 8'h59;
    localparam logic [7:0] ADDR_RES_LOW     = 8'h5a;
    localparam logic [7:0] ADDR_SCAN_CH1    = 8'h5b;
    localparam logic [7:0] ADDR_SCAN_CH2    = 8'h5c;
    localparam logic [7:0] ADDR_SCAN_CH3    = 8'h5d;
    localparam logic [7:0] ADDR_SCAN_CTRL   = 8'h5e;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h60;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h61;

    // Status/control fields.
    localparam int STAT_DONE_BIT  = 7;
    localparam int STAT_IEN_BIT   = 6;
    localparam int STAT_CONT_BIT  = 5;
    // Clock control fields: format lives in bits 3:2.
    localparam int CLK_FMT_LSB    = 2;
    // Scan control fields.
    localparam int SCAN_EN_BIT    = 2;
    localparam int SCAN_LEN_LSB   = 0;
    // Interrupt status fields.
    localparam int IRQ_CONV_BIT   = 0;
    localparam int IRQ_LOST_BIT   = 1;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    typedef enum logic [1:0] {
        ARA_FMT_TRUNC  = 2'b00,
        ARA_FMT_RIGHT  = 2'b01,
        ARA_FMT_LEFT   = 2'b10,
        ARA_FMT_SIGNED = 2'b11
    } ara_fmt_e;

    localparam ara_fmt_e FMT_RESET = ARA_FMT_RIGHT;
endpackage

/* File: hw/ara_fmt_if.sv */
`timescale 1ns/1ps
interface ara_fmt_if;
    import ara_pkg::*;
    ara_fmt_e   fmt;
    logic [9:0] result;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    modport formatter (input fmt, input result, output high_byte, output low_byte);
    modport user (output fmt, output result, input high_byte, input low_byte);
endinterface

/* File: hw/ara_formatter.sv */
`timescale 1ns/1ps
module ara_formatter
    import ara_pkg::*;
(
    ara_fmt_if.formatter f
);
    always_comb begin
        case (f.fmt)
            ARA_FMT_TRUNC: begin
                f.high_byte = 8'h00;
                f.low_byte  = f.result[9:2];
            end
            ARA_FMT_RIGHT: begin
                f.high_byte = {6'h00, f.result[9:8]};
                f.low_byte  = f.result[7:0];
            end
            ARA_FMT_LEFT: begin
                f.high_byte = f.result[9:2];
                f.low_byte  = {f.result[1:0], 6'h00};
            end
            ARA_FMT_SIGNED: begin
                f.high_byte = {~f.result[9], f.result[8:2]};
                f.low_byte  = {f.result[1:0], 6'h00};
            end
            default: begin
                f.high_byte = 8'h00;
                f.low_byte  = 8'h00;
            end
        endcase
    end
endmodule

/* File: hw/ara_top.sv */
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Functional notes
// - High and low result bytes together form one 16-bit word holding the 10-bit result in the justified formats.
// - Truncated format: low byte holds bits 9:2, high byte reads zero.
// - Truncated format rewrites the low byte on every conversion, no interlock.
// - Right-justified: bits 9:8 in high byte 1:0, bits 7:0 in low byte.
// - Left-justified: bits 9:2 in high byte, bits 1:0 in low byte 7:6.
// - Signed left-justified inverts result bit 9 in high byte bit 7.
// - Justified formats update both bytes on each single-channel completion unless the low byte is frozen.
// - Reading the high byte freezes low byte; results dropped until low byte read.
// - Both primary result bytes are read-only and reset to zero.
// - Auto-scan in truncated format stores channels 1 to 3 in own registers.
// - Two-bit scan length selects channels 0 only up to channels 0-3; reset clears.
// - Scan enable turns auto-scan on when one; reset clears it.
// - Two-bit format field selects layout; reset selects right-justified.
// - Without interrupts, done flag sets per conversion, clears on result read.
// - With interrupts, request rises per conversion, drops on result read or status write.
module ara_top
    import ara_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       conv_done,
    input  wire logic [9:0] conv_result,
    output logic      [1:0] scan_channel,
    output logic            continuous_conversion,
    output logic            conversion_irq,
    output logic            irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers.

    logic             conversion_irq_enable_q;
    logic             continuous_q;
    logic [4:0]       chan_sel_q;
    logic [7:0]       clk_ctrl_q;
    logic             scan_enable_q;
    logic [1:0]       scan_len_q;
    logic [1:0]       irq_mask_q;
    logic [1:0]       irq_status_q;
    logic [7:0]       result_high_byte_q;
    logic [7:0]       result_low_byte_q;
    logic [7:0]       scan_res_q [1:3];
    logic             low_frozen_q;
    logic             done_flag_q;
    logic             conv_irq_q;
    logic [1:0]       chan_q;
    logic [7:0]       rdata_q;
    logic             irq_q;

    ara_fmt_e   fmt;
    logic       wr_stat;
    logic       rd_high;
    logic       rd_low;
    logic       accept;
    logic       drop;
    logic       scanning;

    assign fmt      = ara_fmt_e'(clk_ctrl_q[CLK_FMT_LSB +: 2]);
    assign wr_stat  = wr && (addr == ADDR_STAT_CTRL);
    assign rd_high  = rd && (addr == ADDR_RES_HIGH);
    assign rd_low   = rd && (addr == ADDR_RES_LOW);
    assign scanning = scan_enable_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            conversion_irq_enable_q <= 1'b0;
            continuous_q            <= 1'b0;
            chan_sel_q              <= 5'h00;
            clk_ctrl_q              <= {4'h0, FMT_RESET, 2'h0};
            scan_enable_q           <= 1'b0;
            scan_len_q              <= 2'h0;
            irq_mask_q              <= 2'h0;
        end else if (wr) begin
            case (addr)
                ADDR_STAT_CTRL: begin
                    conversion_irq_enable_q <= wdata[STAT_IEN_BIT];
                    continuous_q            <= wdata[STAT_CONT_BIT];
                    chan_sel_q              <= wdata[4:0];
                end
                ADDR_CLK_CTRL:  clk_ctrl_q  <= wdata;
                ADDR_SCAN_CTRL: begin
                    scan_enable_q <= wdata[SCAN_EN_BIT];
                    scan_len_q    <= wdata[SCAN_LEN_LSB +: 2];
                end
                ADDR_IRQ_MASK:  irq_mask_q  <= wdata[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result formatting and the high/low interlock.

    ara_fmt_if fif ();
    assign fif.fmt    = scanning ? ARA_FMT_TRUNC : fmt;
    assign fif.result = conv_result;

    ara_formatter u_fmt (
        .f (fif.formatter)
    );

    // The interlock only guards the justified formats; truncated has none.
    // A high byte read in the same cycle as a completion already counts as a
    // freeze, otherwise the low byte would move under a pair that is half read.
    assign drop   = conv_done && (low_frozen_q || rd_high)
                    && (fmt != ARA_FMT_TRUNC) && !scanning;
    assign accept = conv_done && !drop;

    always_ff @(posedge clk) begin
        if (rst) begin
            low_frozen_q <= 1'b0;
        end else if (rd_low || fmt == ARA_FMT_TRUNC || scanning) begin
            low_frozen_q <= 1'b0;
        end else if (rd_high) begin
            low_frozen_q <= 1'b1;
        end
    end

    // Writes never reach the result bytes; only conversions do.
    always_ff @(posedge clk) begin
        if (rst) begin
            result_high_byte_q <= RESET_BYTE;
            result_low_byte_q  <= RESET_BYTE;
        end else if (accept && (!scanning || chan_q == 2'd0)) begin
            result_high_byte_q <= fif.high_byte;
            result_low_byte_q  <= fif.low_byte;
        end
    end

    // Channel step counter for auto-scan; wraps after the last enabled one.
    always_ff @(posedge clk) begin
        if (rst || !scanning) begin
            chan_q <= 2'd0;
        end else if (conv_done) begin
            chan_q <= (chan_q >= scan_len_q) ? 2'd0 : chan_q + 2'd1;
        end
    end

    genvar gi;
    generate
        for (gi = 1; gi <= 3; gi++) begin : g_scan
            always_ff @(posedge clk) begin
                if (rst) begin
                    scan_res_q[gi] <= RESET_BYTE;
                end else if (conv_done && scanning && fmt == ARA_FMT_TRUNC
                             && chan_q == 2'(gi)) begin
                    scan_res_q[gi] <= fif.low_byte;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Completion flag and converter interrupt.

    always_ff @(posedge clk) begin
        if (rst) begin
            done_flag_q <= 1'b0;
        end else if (conv_done && !conversion_irq_enable_q) begin
            done_flag_q <= 1'b1;
        end else if (rd_high || rd_low || conversion_irq_enable_q) begin
            done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            conv_irq_q <= 1'b0;
        end else if (conv_done && conversion_irq_enable_q) begin
            conv_irq_q <= 1'b1;
        end else if (rd_high || rd_low || wr_stat) begin
            conv_irq_q <= 1'b0;
        end
    end

    // Sticky events: set wins over a simultaneous write-one clear.
    logic [1:0] irq_set;
    assign irq_set = {drop, conv_done};

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_status_q <= 2'h0;
        end else begin
            irq_status_q <= irq_set |
                (irq_status_q & ~((wr && addr == ADDR_IRQ_STATUS) ? wdata[1:0] : 2'h0));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |((irq_status_q | irq_set) & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port.

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (addr)
                ADDR_STAT_CTRL:  rdata_q <= {done_flag_q, conversion_irq_enable_q,
                                             continuous_q, chan_sel_q};
                ADDR_CLK_CTRL:   rdata_q <= clk_ctrl_q;
                ADDR_RES_HIGH:   rdata_q <= result_high_byte_q;
                ADDR_RES_LOW:    rdata_q <= result_low_byte_q;
                ADDR_SCAN_CH1:   rdata_q <= scan_res_q[1];
                ADDR_SCAN_CH2:   rdata_q <= scan_res_q[2];
                ADDR_SCAN_CH3:   rdata_q <= scan_res_q[3];
                ADDR_SCAN_CTRL:  rdata_q <= {5'h00, scan_enable_q, scan_len_q};
                ADDR_IRQ_STATUS: rdata_q <= {6'h00, irq_status_q};
                ADDR_IRQ_MASK:   rdata_q <= {6'h00, irq_mask_q};
                default:         rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata                 = rdata_q;
    assign scan_channel          = chan_q;
    assign continuous_conversion = continuous_q;
    assign conversion_irq        = conv_irq_q;
    assign irq                   = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_trunc_high_zero;
        @(posedge clk) disable iff (rst)
        (fmt == ARA_FMT_TRUNC && conv_done && !scanning) |=> result_high_byte_q == 8'h00;
    endproperty
    a_trunc_high_zero: assert property (p_trunc_high_zero)
        else $error("high byte not zero after truncated conversion");

    property p_trunc_no_lock;
        @(posedge clk) disable iff (rst)
        (fmt == ARA_FMT_TRUNC && conv_done && !scanning) |=>
            result_low_byte_q == $past(conv_result[9:2]);
    endproperty
    a_trunc_no_lock: assert property (p_trunc_no_lock)
        else $error("truncated low byte not rewritten");

    property p_right_just;
        @(posedge clk) disable iff (rst)
        (fmt == ARA_FMT_RIGHT && accept && !scanning) |=>
            {result_high_byte_q, result_low_byte_q} == {6'h00, $past(conv_result)};
    endproperty
    a_right_just: assert property (p_right_just)
        else $error("right-justified layout wrong");

    property p_left_just;
        @(posedge clk) disable iff (rst)
        (fmt == ARA_FMT_LEFT && accept && !scanning) |=>
            {result_high_byte_q, result_low_byte_q} == {$past(conv_result), 6'h00};
    endproperty
    a_left_just: assert property (p_left_just)
        else $error("left-justified layout wrong");

    property p_signed_just;
        @(posedge clk) disable iff (rst)
        (fmt == ARA_FMT_SIGNED && accept && !scanning) |=>
            result_high_byte_q[7] == !$past(conv_result[9]);
    endproperty
    a_signed_just: assert property (p_signed_just)
        else $error("signed format sign bit not inverted");

    property p_freeze;
        @(posedge clk) disable iff (rst)
        (conv_done && (low_frozen_q || rd_high) && fmt != ARA_FMT_TRUNC && !scanning)
            |=> $stable(result_low_byte_q) && $stable(result_high_byte_q);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("low byte changed while frozen");

    property p_done_flag;
        @(posedge clk) disable iff (rst)
        (conv_done && !conversion_irq_enable_q) |=> done_flag_q;
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("done flag not set");

    property p_irq_drop;
        @(posedge clk) disable iff (rst)
        (wr_stat && !conv_done) |=> !conv_irq_q;
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("converter interrupt not dropped on status write");

    property p_scan_wrap;
        @(posedge clk) disable iff (rst)
        (scanning && conv_done && chan_q == scan_len_q && $stable(scan_enable_q))
            |=> chan_q == 2'd0;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap)
        else $error("scan did not wrap after last channel");

    property p_freeze_set;
        @(posedge clk) disable iff (rst)
        (rd_high && fmt != ARA_FMT_TRUNC && !scanning) |=> low_frozen_q;
    endproperty
    a_freeze_set: assert property (p_freeze_set)
        else $error("high byte read did not freeze the low byte");

    property p_scan_low;
        @(posedge clk) disable iff (rst)
        (scanning && conv_done && chan_q == 2'd0) |=>
            result_low_byte_q == $past(conv_result[9:2]);
    endproperty
    a_scan_low: assert property (p_scan_low)
        else $error("channel 0 scan result not in low byte");

    property p_scan_store;
        @(posedge clk) disable iff (rst)
        (scanning && conv_done && fmt == ARA_FMT_TRUNC && chan_q == 2'd1) |=>
            scan_res_q[1] == $past(conv_result[9:2]);
    endproperty
    a_scan_store: assert property (p_scan_store)
        else $error("channel 1 scan result not stored");

    property p_result_ro;
        @(posedge clk) disable iff (rst)
        (wr && !conv_done) |=> $stable(result_high_byte_q) && $stable(result_low_byte_q);
    endproperty
    a_result_ro: assert property (p_result_ro)
        else $error("result byte changed without a conversion");

    property p_done_clear;
        @(posedge clk) disable iff (rst)
        ((rd_high || rd_low) && !conv_done) |=> !done_flag_q;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done flag not cleared by result read");

    c_freeze:    cover property (@(posedge clk) disable iff (rst) drop);
    c_scan3:     cover property (@(posedge clk) disable iff (rst)
                                 scanning && conv_done && chan_q == 2'd3);
    c_irq:       cover property (@(posedge clk) disable iff (rst) conv_irq_q);
    c_signed:    cover property (@(posedge clk) disable iff (rst)
                                 fmt == ARA_FMT_SIGNED && accept);
endmodule

/* File: verif/ara_conv_model.sv */
`timescale 1ns/1ps
// Behavioural converter core: after a start request it waits a chosen number
// of cycles, then gives a one-cycle completion pulse with the sampled value.
module ara_conv_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [9:0] value,
    input  wire logic [3:0] delay,
    output logic            conv_done,
    output logic      [9:0] conv_result
);
    logic [3:0] cnt_q;
    logic [9:0] held_q;

    ////////////////////////////////////////////////////////////////////////////
    // Outside the completion pulse the result bus toggles every cycle, so a
    // design that samples it at the wrong moment picks up garbage.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q       <= 4'h0;
            held_q      <= 10'h000;
            conv_done   <= 1'b0;
            conv_result <= 10'h000;
        end else begin
            conv_done <= 1'b0;
            if (start) begin
                cnt_q  <= delay;
                held_q <= value;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
            if (!start && cnt_q == 4'h1) begin
                conv_done   <= 1'b1;
                conv_result <= held_q;
            end else begin
                conv_result <= ~conv_result;
            end
        end
    end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import ara_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       conv_done;
    logic [9:0] conv_result;
    logic [1:0] scan_channel;
    logic       cont_out;
    logic       conv_irq;
    logic       irq;
    logic       start = 1'b0;
    logic [9:0] value = 10'h000;
    logic [3:0] delay = 4'h1;
    int         miscompares = 0;
    int         tests_run = 0;
    int         f, i, len, k;
    logic [9:0] x;
    logic [7:0] v;
    logic [1:0] ch;
    logic [9:0] xs [2] = '{10'h2c5, 10'h13a};

    always #50 clk = ~clk;

    ara_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .conv_done(conv_done), .conv_result(conv_result),
        .scan_channel(scan_channel), .continuous_conversion(cont_out),
        .conversion_irq(conv_irq), .irq(irq));
    ara_conv_model i_core (.clk(clk), .rst(rst), .start(start), .value(value),
        .delay(delay), .conv_done(conv_done), .conv_result(conv_result));

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    // Returns just after the edge that took the completion pulse.
    task automatic convert(input logic [9:0] val, input logic [3:0] dl);
        int n;
        @(posedge clk);
        start <= 1'b1;
        value <= val;
        delay <= dl;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        #1;
        while (conv_done !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20) begin
            miscompares++;
            finish_test;
        end
        @(posedge clk);
        #1;
    endtask

    function automatic logic [7:0] exp_hi(input logic [1:0] fm, input logic [9:0] r);
        case (fm)
            2'b00: return 8'h00;
            2'b01: return {6'h00, r[9:8]};
            2'b10: return r[9:2];
            default: return {~r[9], r[8:2]};
        endcase
    endfunction

    function automatic logic [7:0] exp_lo(input logic [1:0] fm, input logic [9:0] r);
        case (fm)
            2'b00: return r[9:2];
            2'b01: return r[7:0];
            default: return {r[1:0], 6'h00};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(ADDR_RES_HIGH, 8'h00);
        rd_chk(ADDR_RES_LOW, 8'h00);
        for (i = 0; i < 3; i++) rd_chk(ADDR_SCAN_CH1 + 8'(i), 8'h00);
        rd_chk(ADDR_SCAN_CTRL, 8'h00);
        rd_chk(ADDR_CLK_CTRL, 8'h04);
        rd_chk(8'h7f, 8'h00);
        for (f = 0; f < 4; f++) begin
            for (i = 0; i < 2; i++) begin
                wr_reg(ADDR_CLK_CTRL, {4'h0, 2'(f), 2'b00});
                convert(xs[i], 4'h1);
                rd_chk(ADDR_STAT_CTRL, 8'h80);
                check({7'h00, conv_irq}, 8'h00);
                rd_chk(ADDR_RES_HIGH, exp_hi(2'(f), xs[i]));
                rd_chk(ADDR_RES_LOW, exp_lo(2'(f), xs[i]));
                rd_chk(ADDR_STAT_CTRL, 8'h00);
            end
        end
        wr_reg(ADDR_RES_HIGH, 8'hff);
        wr_reg(ADDR_RES_LOW, 8'hff);
        wr_reg(ADDR_SCAN_CH1, 8'hff);
        rd_chk(ADDR_RES_HIGH, exp_hi(2'b11, xs[1]));
        rd_chk(ADDR_RES_LOW, exp_lo(2'b11, xs[1]));
        rd_chk(ADDR_SCAN_CH1, 8'h00);
        // Interlock, with a slow converter first.
        wr_reg(ADDR_CLK_CTRL, 8'h04);
        convert(10'h155, 4'h6);
        rd_chk(ADDR_RES_HIGH, 8'h01);
        convert(10'h2aa, 4'h1);
        rd_chk(ADDR_RES_LOW, 8'h55);
        rd_chk(ADDR_RES_HIGH, 8'h01);
        rd_chk(ADDR_RES_LOW, 8'h55);
        convert(10'h2aa, 4'h1);
        rd_chk(ADDR_RES_HIGH, 8'h02);
        rd_chk(ADDR_RES_LOW, 8'haa);
        wr_reg(ADDR_CLK_CTRL, 8'h00);
        convert(10'h155, 4'h1);
        rd_chk(ADDR_RES_HIGH, 8'h00);
        convert(10'h2aa, 4'h1);
        rd_chk(ADDR_RES_LOW, 8'haa);
        // Status, mask and the level interrupt.
        rd_chk(ADDR_IRQ_STATUS, 8'h03);
        check({7'h00, irq}, 8'h00);
        wr_reg(ADDR_IRQ_MASK, 8'h02);
        @(posedge clk);
        #1;
        check({7'h00, irq}, 8'h01);
        wr_reg(ADDR_IRQ_STATUS, 8'h02);
        @(posedge clk);
        #1;
        check({7'h00, irq}, 8'h00);
        rd_chk(ADDR_IRQ_STATUS, 8'h01);
        wr_reg(ADDR_IRQ_STATUS, 8'h01);
        rd_chk(ADDR_IRQ_STATUS, 8'h00);
        // Converter interrupt.
        wr_reg(ADDR_STAT_CTRL, 8'h40);
        convert(10'h0f0, 4'h1);
        check({7'h00, conv_irq}, 8'h01);
        rd_chk(ADDR_STAT_CTRL, 8'h40);
        rd_chk(ADDR_RES_HIGH, 8'h00);
        check({7'h00, conv_irq}, 8'h00);
        convert(10'h0f0, 4'h2);
        check({7'h00, conv_irq}, 8'h01);
        wr_reg(ADDR_STAT_CTRL, 8'h20);
        check({7'h00, conv_irq}, 8'h00);
        check({7'h00, cont_out}, 8'h01);
        wr_reg(ADDR_STAT_CTRL, 8'h00);
        // Auto-scan over every length; continuous mode is off here.
        for (len = 0; len < 4; len++) begin
            wr_reg(ADDR_SCAN_CTRL, {5'h00, 1'b1, 2'(len)});
            for (k = 0; k < len + 2; k++) begin
                ch = 2'(k % (len + 1));
                check({6'h00, scan_channel}, {6'h00, ch});
                x = 10'(len * 64 + k * 16 + 9);
                convert(x, 4'h1);
                if (ch == 2'b00)
                    rd_chk(ADDR_RES_LOW, x[9:2]);
                else
                    rd_chk(ADDR_RES_LOW + 8'(ch), x[9:2]);
            end
            wr_reg(ADDR_SCAN_CTRL, 8'h00);
            @(posedge clk);
            #1;
            check({6'h00, scan_channel}, 8'h00);
        end
        finish_test;
    end
endmodule
